// *** plpsc_pkg.sv ***
// Package for the PHY link power-status controller: register map, field layout,
// reset values, timing constants and the packed carriers shared by the design.
// Assumes a 40 MHz system clock and a free-running PHY clock source for the link side.
package plpsc_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] PLPSC_OFS_CTRL = 8'h00;
  localparam logic [7:0] PLPSC_OFS_PORT_CFG = 8'h04;
  localparam logic [7:0] PLPSC_OFS_STATUS = 8'h08;

  // Control register fields
  localparam int PLPSC_CTRL_LINK_ACTIVE_BIT = 0;
  localparam logic PLPSC_CTRL_RESET = 1'h0;

  // Port configuration layout: disabled [2:0], hard-disabled [5:3], sleep-enable [8:6]
  localparam int PLPSC_CFG_DIS_LSB = 0;
  localparam int PLPSC_CFG_HARD_LSB = 3;
  localparam int PLPSC_CFG_SLEEP_LSB = 6;
  localparam logic [8:0] PLPSC_CFG_RESET = 9'h000;

  // Status register fields
  localparam int PLPSC_ST_LPS_ACTIVE_BIT = 0;
  localparam int PLPSC_ST_STATE_LSB = 1;
  localparam int PLPSC_ST_PMC_BIT = 4;
  localparam int PLPSC_ST_LINK_REPORT_BIT = 5;
  localparam int PLPSC_ST_CPD_LSB = 8;

  // Data line positions used in the no-link power management mode
  localparam int PLPSC_D_ALL_PORTS_BIT = 6;

  // Timing on the system clock
  localparam int PLPSC_SYS_CLK_PERIOD_NS = 25;
  localparam int PLPSC_LPS_RESET_NS = 2600;
  localparam int PLPSC_LPS_DISABLE_NS = 26000;
  localparam logic [10:0] PLPSC_LPS_RESET_CYC =
    11'((PLPSC_LPS_RESET_NS + PLPSC_SYS_CLK_PERIOD_NS - 1) / PLPSC_SYS_CLK_PERIOD_NS);
  localparam logic [10:0] PLPSC_LPS_DISABLE_CYC =
    11'((PLPSC_LPS_DISABLE_NS + PLPSC_SYS_CLK_PERIOD_NS - 1) / PLPSC_SYS_CLK_PERIOD_NS);
  localparam logic [10:0] PLPSC_LOW_CNT_MAX = 11'h7FF;

  // Link side: how long a seen-high sample is stretched, in PHY source cycles
  localparam logic [3:0] PLPSC_LPS_STRETCH = 4'hF;
  // Cycles after reset release before the strap levels are trusted
  localparam logic [1:0] PLPSC_STRAP_SETTLE = 2'h2;

  // Per-port configuration written by software
  typedef struct packed {
    logic [2:0] sleep_enable;
    logic [2:0] hard_disabled;
    logic [2:0] disabled;
  } plpsc_port_cfg_type;

  // Per-port line condition reported by the port logic
  typedef struct packed {
    logic [2:0] active;
    logic [2:0] ds_mode;
    logic [2:0] asleep;
    logic [2:0] connected;
  } plpsc_port_state_type;

  // Control and data lines toward the link controller
  typedef struct packed {
    logic ctl_oe;
    logic [1:0] ctl;
    logic data_oe;
    logic [7:0] data;
  } plpsc_if_lines_type;

  // Interface power state, one-hot
  typedef enum logic [2:0] {
    PLPSC_IF_ACTIVE = 3'b001,
    PLPSC_IF_RESET = 3'b010,
    PLPSC_IF_DISABLED = 3'b100
  } plpsc_if_state_type;

endpackage

// *** plpsc_ctrl.sv ***
// PHY link power-status controller: filters the link power status input, steps the
// link interface through active, reset and disabled states, gates the PHY clock,
// reports link activity for self-ID and drives cable-power-disable in no-link mode.
// Assumes sys_clk at 40 MHz and phy_src_clk at twice the PHY clock rate in beta mode.
//
// Functional notes
// - Sample link clock mode strap at reset; with status and beta select pick no-link mode.
// - In no-link mode data bit 0 is port 0 cable-power disable.
// - In no-link mode data bits 1 and 2 are port 1 and 2 disables.
// - In no-link mode data bit 6 is the AND of bits 0 to 2.
// - Data bits 3 to 5 and 7 are reserved in no-link mode.
// - Disable cable power when port disabled and hard-disabled bits are both set.
// - Disable cable power when port disabled and sleep-enable bits are both set.
// - Disable cable power when disconnected, asleep, or connected data-strobe but not active.
// - Otherwise, dc-connected or active, cable power stays enabled.
// - Status inactive after low longer than about 2.6 us, active otherwise.
// - Inactive status: interface reset, lines held at 0, requests ignored, clock runs.
// - Low longer than about 26 us: interface disabled and PHY clock held inactive.
// - Self-ID reports link active only with status active and link-active bit 1.
// - PHY clock is 98.304 MHz in beta mode, 49.152 MHz in legacy mode.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
module plpsc_ctrl
  import plpsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic phy_src_clk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_power_status,
  input wire logic link_clock_mode_strap,
  input wire logic beta_mode_select,
  input wire logic link_request,
  input wire plpsc_port_state_type port_state,
  input wire plpsc_if_lines_type pkt_lines,
  output plpsc_if_lines_type if_lines,
  output logic phy_clk,
  output logic link_request_taken,
  output logic self_id_link_active,
  output logic no_link_power_mgmt_mode
);

  // Cable-power-disable decision for one port
  function automatic logic cpd_of(input logic dis, input logic hard, input logic sleep,
                                  input logic conn, input logic asleep, input logic ds,
                                  input logic act);
    cpd_of = (dis & hard) | (dis & sleep) | ~conn | asleep | (conn & ds & ~act);
  endfunction

  // System-domain state
  logic link_active_control_bit;
  plpsc_port_cfg_type port_cfg;
  plpsc_if_state_type state;
  plpsc_if_state_type next_state;
  logic [10:0] low_cnt;
  logic [10:0] next_low_cnt;
  logic lps_hold_s1;
  logic lps_hold_s2;
  logic strap_s1;
  logic strap_s2;
  logic lps_pin_s1;
  logic lps_pin_s2;
  logic beta_mode_select_s1;
  logic beta_mode_select_s2;
  logic [1:0] settle;
  logic [2:0] cpd;
  logic [5:0] xfer;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // Link-domain state
  logic lrst_s1;
  logic link_rst_n;
  logic llps_s1;
  logic llps_s2;
  logic [3:0] stretch_cnt;
  logic lps_hold;
  logic [5:0] xfer_s1;
  logic [5:0] xfer_s2;
  logic [5:0] xfer_s3;
  logic [5:0] xfer_ok;
  logic lbmode_s1;
  logic lbmode_s2;
  logic link_request_s1;
  logic link_request_s2;
  logic div_phase;
  plpsc_if_lines_type next_lines;

  // Named decodes
  wire logic lps_seen = lps_hold_s2;
  wire logic lps_active = state == PLPSC_IF_ACTIVE; // Filtered: pulsed status counts as active
  wire logic setup_phase = psel & ~penable;
  wire logic wr_access = psel & penable & pwrite;
  wire logic hit_ctrl = paddr == PLPSC_OFS_CTRL;
  wire logic hit_cfg = paddr == PLPSC_OFS_PORT_CFG;
  wire logic hit_status = paddr == PLPSC_OFS_STATUS;
  wire logic hit_any = hit_ctrl | hit_cfg | hit_status;
  wire logic [2:0] next_cpd;
  wire logic [31:0] status_word;
  wire logic [2:0] cpd_l = xfer_ok[2:0];
  wire logic force_zero_l = xfer_ok[3];
  wire logic clk_stop_l = xfer_ok[4];
  wire logic pmc_l = xfer_ok[5];

  // Per-port cable-power disable, one decode per port
  generate
    for (genvar p = 0; p < 3; p++) begin : g_cpd
      assign next_cpd[p] = cpd_of(port_cfg.disabled[p], port_cfg.hard_disabled[p],
                                  port_cfg.sleep_enable[p], port_state.connected[p],
                                  port_state.asleep[p], port_state.ds_mode[p],
                                  port_state.active[p]);
    end
  endgenerate

  // Status word for software
  assign status_word = {21'h000000, cpd, 2'h0, self_id_link_active, no_link_power_mgmt_mode,
                        state, lps_active};

  // APB read data and error, latched in the setup phase so the access phase can end at once
  assign next_prdata = hit_ctrl ? {31'h00000000, link_active_control_bit} :
                       hit_cfg ? {23'h000000, port_cfg} :
                       hit_status ? status_word : 32'h00000000;
  assign next_pslverr = ~hit_any;
  assign pready = 1'b1;

  // APB register file and latched answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_active_control_bit <= PLPSC_CTRL_RESET;
      port_cfg <= PLPSC_CFG_RESET;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      if (setup_phase) begin
        prdata <= next_prdata;
        pslverr <= next_pslverr;
      end
      if (wr_access && hit_ctrl) begin
        link_active_control_bit <= pwdata[PLPSC_CTRL_LINK_ACTIVE_BIT];
      end
      if (wr_access && hit_cfg) begin
        port_cfg <= plpsc_port_cfg_type'(pwdata[8:0]);
      end
    end
  end

  // Pin synchronisers for the strap levels and the stretched status from the link side
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {strap_s1, strap_s2, lps_pin_s1, lps_pin_s2} <= 4'h0;
      {beta_mode_select_s1, beta_mode_select_s2, lps_hold_s1, lps_hold_s2} <= 4'h0;
    end else begin
      {strap_s1, strap_s2} <= {link_clock_mode_strap, strap_s1};
      {lps_pin_s1, lps_pin_s2} <= {link_power_status, lps_pin_s1};
      {beta_mode_select_s1, beta_mode_select_s2} <= {beta_mode_select, beta_mode_select_s1};
      {lps_hold_s1, lps_hold_s2} <= {lps_hold, lps_hold_s1};
    end
  end

  // Strap capture once the synchronisers hold post-reset levels; pins are not read at reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle <= 2'h0;
      no_link_power_mgmt_mode <= 1'b0;
    end else begin
      if (settle != 2'h3) begin
        settle <= settle + 2'h1;
      end
      if (settle == PLPSC_STRAP_SETTLE) begin
        no_link_power_mgmt_mode <= strap_s2 & ~lps_pin_s2 & beta_mode_select_s2;
      end
    end
  end

  // Low-time counter saturates so a long-dead link stays disabled
  assign next_low_cnt = lps_seen ? 11'h000 :
                        (low_cnt == PLPSC_LOW_CNT_MAX) ? low_cnt : low_cnt + 11'h001;

  // Interface power state machine
  always_comb begin
    case (state)
      PLPSC_IF_ACTIVE: begin
        if (!lps_seen && low_cnt >= PLPSC_LPS_RESET_CYC) begin
          next_state = PLPSC_IF_RESET;
        end else begin
          next_state = PLPSC_IF_ACTIVE;
        end
      end
      PLPSC_IF_RESET: begin
        if (lps_seen) begin
          next_state = PLPSC_IF_ACTIVE;
        end else if (low_cnt >= PLPSC_LPS_DISABLE_CYC) begin
          next_state = PLPSC_IF_DISABLED;
        end else begin
          next_state = PLPSC_IF_RESET;
        end
      end
      PLPSC_IF_DISABLED: begin
        next_state = lps_seen ? PLPSC_IF_ACTIVE : PLPSC_IF_DISABLED;
      end
      default: begin
        next_state = PLPSC_IF_RESET;
      end
    endcase
  end

  // State, counter, outputs and the level bundle handed to the link side
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PLPSC_IF_RESET;
      low_cnt <= 11'h000;
      cpd <= 3'h0;
      self_id_link_active <= 1'b0;
      xfer <= 6'h18;
    end else begin
      state <= next_state;
      low_cnt <= next_low_cnt;
      cpd <= next_cpd;
      self_id_link_active <= lps_active & link_active_control_bit;
      xfer <= {no_link_power_mgmt_mode, next_state == PLPSC_IF_DISABLED,
               next_state != PLPSC_IF_ACTIVE, cpd};
    end
  end

  // Link-side reset: asserted at once, released in step with the PHY source clock
  always_ff @(posedge phy_src_clk or negedge rst_n) begin
    if (!rst_n) begin
      {lrst_s1, link_rst_n} <= 2'h0;
    end else begin
      {lrst_s1, link_rst_n} <= {1'b1, lrst_s1};
    end
  end

  // Link-side synchronisers; the control word is used only once two samples agree
  always_ff @(posedge phy_src_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      {llps_s1, llps_s2, lbmode_s1, lbmode_s2, link_request_s1, link_request_s2} <= 6'h00;
      xfer_s1 <= 6'h18;
      xfer_s2 <= 6'h18;
      xfer_s3 <= 6'h18;
      xfer_ok <= 6'h18;
    end else begin
      {llps_s1, llps_s2} <= {link_power_status, llps_s1};
      {lbmode_s1, lbmode_s2} <= {beta_mode_select, lbmode_s1};
      {link_request_s1, link_request_s2} <= {link_request, link_request_s1};
      xfer_s1 <= xfer;
      xfer_s2 <= xfer_s1;
      xfer_s3 <= xfer_s2;
      xfer_ok <= (xfer_s3 == xfer_s2) ? xfer_s2 : xfer_ok; // A torn word never agrees twice
    end
  end

  // Stretch each seen-high so the slower system clock cannot miss a short pulse
  always_ff @(posedge phy_src_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      stretch_cnt <= 4'h0;
      lps_hold <= 1'b0;
    end else begin
      if (llps_s2) begin
        stretch_cnt <= PLPSC_LPS_STRETCH;
      end else if (stretch_cnt != 4'h0) begin
        stretch_cnt <= stretch_cnt - 4'h1;
      end
      lps_hold <= llps_s2 | (stretch_cnt != 4'h0);
    end
  end

  // Line drive: no-link mode shows port disables, reset and disabled force zeros, else packet traffic
  always_comb begin
    next_lines = pkt_lines;
    if (pmc_l) begin
      next_lines = '{ctl_oe: 1'b1, ctl: 2'h0, data_oe: 1'b1, data: 8'h00};
      next_lines.data[2:0] = cpd_l;
      next_lines.data[PLPSC_D_ALL_PORTS_BIT] = &cpd_l;
    end else if (force_zero_l) begin
      next_lines = '{ctl_oe: 1'b1, ctl: 2'h0, data_oe: 1'b1, data: 8'h00};
    end
  end

  // Registered lines, request gate and the PHY clock divider
  always_ff @(posedge phy_src_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      if_lines <= '{ctl_oe: 1'b1, ctl: 2'h0, data_oe: 1'b1, data: 8'h00};
      link_request_taken <= 1'b0;
      div_phase <= 1'b0;
      phy_clk <= 1'b0;
    end else begin
      if_lines <= next_lines;
      link_request_taken <= link_request_s2 & ~force_zero_l & ~pmc_l;
      div_phase <= ~div_phase;
      if (clk_stop_l) begin
        phy_clk <= 1'b0;
      end else if (lbmode_s2 || div_phase) begin
        phy_clk <= ~phy_clk;
      end
    end
  end

  // Checks in the system domain
  sequence low_long_active;
    state == PLPSC_IF_ACTIVE && !lps_seen && low_cnt >= PLPSC_LPS_RESET_CYC;
  endsequence
  AST_STRAP_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    settle == PLPSC_STRAP_SETTLE |=>
      no_link_power_mgmt_mode == $past(strap_s2 & ~lps_pin_s2 & beta_mode_select_s2))
    else $error("no-link mode does not match the sampled straps");
  AST_CPD_CONFIG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> (($past(port_cfg.disabled & (port_cfg.hard_disabled | port_cfg.sleep_enable))
              & ~cpd) == 3'h0))
    else $error("configured port disable did not remove cable power");
  AST_CPD_LINE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> cpd == $past(~port_state.connected | port_state.asleep |
                          (port_state.connected & port_state.ds_mode & ~port_state.active) |
                          (port_cfg.disabled & (port_cfg.hard_disabled | port_cfg.sleep_enable))))
    else $error("cable power disable does not follow port condition");
  AST_LPS_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    low_long_active |=> state == PLPSC_IF_RESET ##1 state != PLPSC_IF_ACTIVE || lps_seen)
    else $error("status low too long but interface not reset");
  AST_LPS_HELD_ACTIVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PLPSC_IF_ACTIVE && low_cnt < PLPSC_LPS_RESET_CYC |=> state == PLPSC_IF_ACTIVE)
    else $error("interface left active before the low time elapsed");
  AST_LPS_DISABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == PLPSC_IF_RESET && !lps_seen && low_cnt >= PLPSC_LPS_DISABLE_CYC
      |=> state == PLPSC_IF_DISABLED)
    else $error("status low past disable time but interface not disabled");
  AST_LPS_RECOVER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lps_seen |=> state == PLPSC_IF_ACTIVE ##1 low_cnt == 11'h000 || !lps_seen)
    else $error("interface did not return to active");
  AST_LINK_REPORT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 self_id_link_active == $past(lps_active & link_active_control_bit))
    else $error("self-ID link state wrong");
  // Checks in the link domain
  sequence stop_held;
    clk_stop_l ##1 clk_stop_l;
  endsequence
  sequence run_beta;
    !clk_stop_l && lbmode_s2 ##1 !clk_stop_l && lbmode_s2;
  endsequence

  AST_PMC_LINES: assert property (@(posedge phy_src_clk) disable iff (!link_rst_n)
    pmc_l |=> if_lines.data[2:0] == $past(cpd_l) && if_lines.data_oe)
    else $error("port disable bits not on data lines");
  AST_PMC_ALL: assert property (@(posedge phy_src_clk) disable iff (!link_rst_n)
    pmc_l |=> if_lines.data[6] == &$past(cpd_l) && if_lines.data[5:3] == 3'h0
      && !if_lines.data[7])
    else $error("all-ports bit or reserved data bits wrong");
  AST_RESET_ZERO: assert property (@(posedge phy_src_clk) disable iff (!link_rst_n)
    force_zero_l && !pmc_l |=> if_lines.ctl == 2'h0 && if_lines.data == 8'h00
      && !link_request_taken)
    else $error("interface lines not held at zero in reset state");
  AST_CLK_STOP: assert property (@(posedge phy_src_clk) disable iff (!link_rst_n)
    stop_held |-> !phy_clk)
    else $error("PHY clock running while interface disabled");
  AST_CLK_BETA: assert property (@(posedge phy_src_clk) disable iff (!link_rst_n)
    run_beta |=> phy_clk != $past(phy_clk))
    else $error("PHY clock not toggling every cycle in beta mode");

endmodule

// *** plpsc_link_model.sv ***
// Link controller stand-in: drives link power status and link requests.
// Assumes the bench picks the power mode and the request level.
`timescale 1ns/10ps
module plpsc_link_model (
  input wire logic phy_clk,
  input wire logic [1:0] lps_mode,
  input wire logic req_go,
  output logic link_power_status,
  output logic link_request
);
  // Mode 0 powered off, 1 held high, 2 pulsed as across an isolation barrier
  initial begin
    link_power_status = 1'b0;
    forever begin
      if (lps_mode == 2'h2) begin
        link_power_status = 1'b1;
        #25; // High phase kept above the minimum
        link_power_status = 1'b0;
        #1500;
      end else begin
        link_power_status = (lps_mode == 2'h1);
        #5;
      end
    end
  end

  // Requests launch on the PHY clock, so they freeze while it is stopped
  initial link_request = 1'b0;
  always @(posedge phy_clk) link_request <= req_go;
endmodule

// *** tb_phy_link_power_status_ctrl.sv ***
// Self-checking bench for the link power-status controller.
// Assumes the package constants and a link model on the far side.
`timescale 1ns/10ps
module tb_phy_link_power_status_ctrl;
  import plpsc_pkg::*;
  logic sys_clk = 1'b0;
  logic phy_src_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, phy_clk, link_request_taken;
  logic self_id_link_active, no_link_power_mgmt_mode;
  logic link_power_status, link_request;
  logic link_clock_mode_strap = 1'b0;
  logic beta_mode_select = 1'b1;
  logic req_go = 1'b0;
  logic [1:0] lps_mode = 2'h1;
  plpsc_port_state_type port_state = '0;
  plpsc_if_lines_type pkt_lines = '0;
  plpsc_if_lines_type if_lines;
  logic [31:0] exp_q[$];
  logic [31:0] got_q[$];
  int mismatches = 0;
  int compares = 0;
  int seed = 33;
  int pcount;

  // Clocks; the link source is offset so the two never line up
  always #12.5 sys_clk = ~sys_clk;
  initial #1.3 forever #3 phy_src_clk = ~phy_src_clk;

  plpsc_ctrl u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .phy_src_clk(phy_src_clk),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_power_status(link_power_status), .link_clock_mode_strap(link_clock_mode_strap),
    .beta_mode_select(beta_mode_select), .link_request(link_request),
    .port_state(port_state), .pkt_lines(pkt_lines), .if_lines(if_lines), .phy_clk(phy_clk),
    .link_request_taken(link_request_taken), .self_id_link_active(self_id_link_active),
    .no_link_power_mgmt_mode(no_link_power_mgmt_mode)
  );
  plpsc_link_model u_link (
    .phy_clk(phy_clk), .lps_mode(lps_mode), .req_go(req_go),
    .link_power_status(link_power_status), .link_request(link_request)
  );

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Monitor pairs every observed result with the oldest expectation
  always @(posedge sys_clk)
    while (got_q.size() > 0) chk(exp_q.pop_front(), got_q.pop_front());

  task automatic note(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask

  // One APB transfer; error flag folded into bit 31, which no register uses
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1); // Only the watchdog ends a stuck wait
    r = (prdata & 32'h7FFFFFFF) | {pslverr, 31'h0};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    note(e, r & m);
  endtask

  // Counts PHY clock rising edges over 40 system cycles
  task automatic pclk_live(output logic alive);
    pcount = 0;
    fork
      repeat (40) @(posedge sys_clk);
      forever @(posedge phy_clk) pcount++;
    join_any
    disable fork;
    alive = (pcount > 0);
  endtask

  // PHY clock period in units of 10 ps
  task automatic period(output logic [31:0] p);
    realtime t;
    @(posedge phy_clk);
    t = $realtime;
    @(posedge phy_clk);
    p = 32'(int'(($realtime - t) * 100.0));
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watchdog: the run needs about 2200 cycles
  initial begin
    repeat (8000) @(posedge sys_clk);
    mismatches++;
    close_out;
  end

  initial begin
    logic [31:0] r;
    logic alive;
    logic [8:0] cfg;
    logic [2:0] cpd;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge sys_clk);
    // Register defaults, unmapped access, link reported active
    note(32'h0, {31'h0, no_link_power_mgmt_mode});
    rd(PLPSC_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rd(PLPSC_OFS_PORT_CFG, 32'hFFFFFFFF, 32'h0);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C, 32'hFFFFFFFF, 32'h80000000);
    rd(PLPSC_OFS_STATUS, 32'hE, {28'h0, PLPSC_IF_ACTIVE, 1'b0});
    wr(PLPSC_OFS_CTRL, 32'h1);
    rd(PLPSC_OFS_STATUS, 32'h20, 32'h20);
    note(32'h1, {31'h0, self_id_link_active});
    pkt_lines <= 12'($random(seed));
    req_go <= 1'b1;
    repeat (10) @(posedge sys_clk);
    note({19'h0, 1'b1, pkt_lines}, {19'h0, link_request_taken, if_lines});
    // Clock rate follows the beta select level
    beta_mode_select <= 1'b0;
    repeat (10) @(posedge sys_clk);
    period(r);
    note(32'(2400), r);
    beta_mode_select <= 1'b1;
    repeat (10) @(posedge sys_clk);
    period(r);
    note(32'(1200), r);
    // Short low spells and pulses keep the link active
    lps_mode <= 2'h0;
    repeat (80) @(posedge sys_clk);
    rd(PLPSC_OFS_STATUS, 32'hE, {28'h0, PLPSC_IF_ACTIVE, 1'b0});
    lps_mode <= 2'h2;
    repeat (300) @(posedge sys_clk);
    rd(PLPSC_OFS_STATUS, 32'h21, 32'h21);
    // Long low: lines held at zero, requests ignored, clock still runs
    lps_mode <= 2'h0;
    repeat (160) @(posedge sys_clk);
    rd(PLPSC_OFS_STATUS, 32'h2E, {28'h0, PLPSC_IF_RESET, 1'b0});
    pclk_live(alive);
    note({18'h0, 2'b10, 12'h900}, {18'h0, alive, link_request_taken, if_lines});
    // Past the disable time the PHY clock stops low
    repeat (1000) @(posedge sys_clk);
    rd(PLPSC_OFS_STATUS, 32'hE, {28'h0, PLPSC_IF_DISABLED, 1'b0});
    pclk_live(alive);
    note(32'h0, {30'h0, alive, phy_clk});
    // Link powers up again
    lps_mode <= 2'h1;
    repeat (20) @(posedge sys_clk);
    rd(PLPSC_OFS_STATUS, 32'hE, {28'h0, PLPSC_IF_ACTIVE, 1'b0});
    pclk_live(alive);
    note({18'h0, 2'b11, pkt_lines}, {18'h0, alive, link_request_taken, if_lines});
    req_go <= 1'b0;
    wr(PLPSC_OFS_CTRL, 32'h0);
    rd(PLPSC_OFS_STATUS, 32'h20, 32'h0);
    // Restart without a link: strap high, status low, beta high
    rst_n <= 1'b0;
    link_clock_mode_strap <= 1'b1;
    lps_mode <= 2'h0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    note(32'h1, {31'h0, no_link_power_mgmt_mode});
    repeat (16) begin
      cfg = 9'($random(seed));
      port_state <= 12'($random(seed));
      wr(PLPSC_OFS_PORT_CFG, {23'h0, cfg});
      repeat (12) @(posedge sys_clk);
      cpd = (cfg[2:0] & (cfg[5:3] | cfg[8:6])) | ~port_state.connected | port_state.asleep
            | (port_state.connected & port_state.ds_mode & ~port_state.active);
      rd(PLPSC_OFS_STATUS, 32'h700, {21'h0, cpd, 8'h0});
      note({20'h0, 4'h9, 1'b0, &cpd, 3'h0, cpd}, {20'h0, if_lines});
    end
    repeat (4) @(posedge sys_clk);
    close_out;
  end
endmodule
